// ### common/rsw_params.svh
`ifndef RSW_PARAMS_SVH
`define RSW_PARAMS_SVH

// clock and oscillator
`define RSW_CLK_HZ 250000000
`define RSW_CLK_PERIOD_NS 4
`define RSW_OSC_HZ 32768
`define RSW_HALF_DIV ((`RSW_CLK_HZ + `RSW_OSC_HZ) / (2 * `RSW_OSC_HZ))

// reset input qualification and recovery
`define RSW_TR1_NS 50
`define RSW_TR1_CYC ((`RSW_TR1_NS + `RSW_CLK_PERIOD_NS - 1) / `RSW_CLK_PERIOD_NS)
`define RSW_TR2_MS 20
`define RSW_TR2_CYC (`RSW_TR2_MS * (`RSW_CLK_HZ / 1000))
`define RSW_RESET_RECOVERY_TIME_MS 40
`define RSW_RESET_RECOVERY_TIME_CYC (`RSW_RESET_RECOVERY_TIME_MS * (`RSW_CLK_HZ / 1000))

// register byte addresses
`define RSW_ADDR_FLAGS 19'h7fff0
`define RSW_ADDR_AMON 19'h7fff6
`define RSW_ADDR_WDOG 19'h7fff7
`define RSW_ADDR_CTRL 19'h7fff8
`define RSW_ADDR_SECS 19'h7fff9
`define RSW_ADDR_WDAY 19'h7fffc

// field positions
`define RSW_AM_AFE 7
`define RSW_AM_SQUARE_WAVE_ENABLE 6
`define RSW_AM_ABE 5
`define RSW_WD_STEER 7
`define RSW_CAL_SIGN 5
`define RSW_SEC_STOP 7
`define RSW_DAY_FT 6

// timing chain
`define RSW_WD_BASE 2048
`define RSW_SEC_OSC 32768
`define RSW_CAL_SHORT 128
`define RSW_CAL_LONG 256
`define RSW_CAL_MINUTES 6'h3e
`define RSW_LAST_SEC 6'h3b
`define RSW_FT_BIT 6

`endif

// ### common/rsw_pkg.sv
package rsw_pkg;

    typedef enum logic [1:0] {RSW_RST_IDLE, RSW_RST_HOLD, RSW_RST_RECOVER} rsw_rst_state_t;

    typedef struct packed {
        // registers
        logic watchdog_timeout_flag;
        logic [3:0] rate;
        logic afe;
        logic square_wave_enable;
        logic abe;
        logic [4:0] amon;
        logic [7:0] wd;
        logic [7:0] ctl;
        logic st;
        logic [6:0] secs;
        logic ft;
        logic [2:0] wday;
        // bus tracking
        logic rd_act;
        logic [18:0] addr_last;
        logic [7:0] rd_data;
        logic data_oe;
        logic wr_act;
        logic [18:0] wr_addr;
        logic [7:0] wr_data;
        // oscillator chain
        logic [15:0] half_cnt;
        logic [15:0] ph;
        logic [15:0] sec_pre;
        logic [5:0] sec_cnt;
        logic [5:0] min_cnt;
        logic sec_tick;
        // watchdog
        logic kick_last;
        logic [16:0] wd_pre;
        logic [4:0] wd_cnt;
        logic wd_done;
        logic wd_irq;
        // reset output
        rsw_rst_state_t rst_st;
        logic [23:0] rst_cnt;
        // pins
        logic irq_out;
        logic irq_oe;
        logic square_wave_pin;
        logic sqw_oe;
        logic rst_out;
        logic rst_oe;
    } rsw_state_t;

endpackage

// ### rtl/rsw_rst_qual.sv
`timescale 1ns/1ps
module rsw_rst_qual
    import rsw_pkg::*;
#(
    parameter int unsigned QUAL_CYC = 13,
    parameter int CW = 8
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // synchronised input, high while the pin is low
    input wire logic i_low,
    // qualified reset request
    output logic o_hit
);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic hit;
    } rsw_qual_state_t;

    rsw_qual_state_t s_r, s_nxt;

    // shorter lows never reach the end of the count
    always_comb begin
        s_nxt = s_r;
        if (!i_low) begin
            s_nxt.cnt = '0;
            s_nxt.hit = 1'b0;
        end else if (s_r.cnt == CW'(QUAL_CYC - 1)) begin
            s_nxt.hit = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + CW'(1);
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_hit = s_r.hit;
endmodule // rsw_rst_qual

// ### rtl/rsw_supervisor.sv
`timescale 1ns/1ps
`include "rsw_params.svh"

module rsw_supervisor
    import rsw_pkg::*;
#(
    parameter int unsigned HALF_DIV = `RSW_HALF_DIV,
    parameter int unsigned DEB_CYC = `RSW_TR2_CYC,
    parameter int unsigned REC_CYC = `RSW_RESET_RECOVERY_TIME_CYC
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // host bus pins
    input wire logic [18:0] i_addr,
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe,
    // supervisor pins
    input wire logic i_watchdog_kick_input,
    input wire logic i_fast_reset_input_n,
    input wire logic i_debounced_reset_input_n,
    input wire logic i_power_fail,
    // alarm match from the timekeeping core
    input wire logic i_alarm_flag,
    // open-drain and tristate outputs
    output logic o_interrupt_test_pin_out,
    output logic o_interrupt_test_pin_oe,
    output logic o_square_wave_pin,
    output logic o_square_wave_pin_oe,
    output logic o_reset_out,
    output logic o_reset_oe,
    // calibrated one-second tick
    output logic o_second_tick
);
    localparam int PW = 34;
    localparam logic [PW-1:0] PIN_IDLE = {19'h0, 8'h0, 3'h7, 1'b0, 1'b0, 2'h3};

    rsw_state_t s_r, s_nxt;
    logic [PW-1:0] pin_q;
    logic [18:0] addr_q;
    logic [7:0] data_q;
    logic ce_n_q, oe_n_q, we_n_q, kick_q, pf_q, rin1_n_q, rin2_n_q;
    logic fast_hit, deb_hit, ext_rst, hold_src;
    logic rd_cond, new_rd, wr_cond, commit, wd_wr, kick_edge;
    logic half_tick, osc_tick, wd_run, res_wrap, tmo, ft_active, cal_here;
    logic [4:0] wd_mult;
    logic [16:0] res_last;
    logic [15:0] sec_last;
    logic [7:0] rd_mux;

    rsw_sync #(
        .W(PW),
        .RST_VAL(PIN_IDLE)
    ) u_pin_sync (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_async({i_addr, i_data, i_ce_n, i_oe_n, i_we_n, i_watchdog_kick_input, i_power_fail,
                  i_fast_reset_input_n, i_debounced_reset_input_n}),
        .o_level(pin_q)
    );

    assign {addr_q, data_q, ce_n_q, oe_n_q, we_n_q, kick_q, pf_q, rin1_n_q, rin2_n_q} = pin_q;

    rsw_rst_qual #(
        .QUAL_CYC(`RSW_TR1_CYC),
        .CW(8)
    ) u_fast_qual (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_low(!rin1_n_q),
        .o_hit(fast_hit)
    );

    rsw_rst_qual #(
        .QUAL_CYC(DEB_CYC),
        .CW(24)
    ) u_deb_qual (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_low(!rin2_n_q),
        .o_hit(deb_hit)
    );

    assign ext_rst = fast_hit || deb_hit;
    assign hold_src = pf_q || ext_rst;

    // bus decode; the device is deselected during power fail
    assign rd_cond = !ce_n_q && !oe_n_q && we_n_q && !pf_q;
    assign new_rd = rd_cond && (!s_r.rd_act || addr_q != s_r.addr_last);
    assign wr_cond = !ce_n_q && !we_n_q && !pf_q;
    assign commit = s_r.wr_act && !wr_cond;
    assign wd_wr = commit && s_r.wr_addr == `RSW_ADDR_WDOG;
    assign kick_edge = kick_q != s_r.kick_last;

    // oscillator chain: ph advances at twice the oscillator rate
    assign half_tick = s_r.half_cnt == 16'(HALF_DIV - 1);
    assign osc_tick = half_tick && !s_r.st && s_r.ph[0];

    // watchdog timing
    assign wd_mult = s_r.wd[6:2];
    assign wd_run = wd_mult != 5'h00 && !s_r.wd_done;
    assign res_last = 17'((`RSW_WD_BASE << {s_r.wd[1:0], 1'b0}) - 1);
    assign res_wrap = s_r.wd_pre == res_last;
    assign tmo = osc_tick && wd_run && res_wrap && 5'(s_r.wd_cnt + 5'h01) == wd_mult
                 && !wd_wr && !kick_edge && !hold_src;

    // test output: needs steering to reset or an idle watchdog
    assign ft_active = !s_r.st && s_r.ft && !s_r.afe
                       && (s_r.wd[`RSW_WD_STEER] || s_r.wd == 8'h00);

    // calibration trims second zero of the first 2N minutes
    assign cal_here = s_r.sec_cnt == 6'h00 && s_r.min_cnt < {s_r.ctl[4:0], 1'b0}
                      && s_r.min_cnt < `RSW_CAL_MINUTES;
    assign sec_last = !cal_here ? 16'(`RSW_SEC_OSC - 1) :
                      s_r.ctl[`RSW_CAL_SIGN] ? 16'(`RSW_SEC_OSC - `RSW_CAL_SHORT - 1) :
                      16'(`RSW_SEC_OSC + `RSW_CAL_LONG - 1);

    always_comb begin
        case (addr_q)
            `RSW_ADDR_FLAGS: rd_mux = {s_r.watchdog_timeout_flag, 3'h0, s_r.rate};
            `RSW_ADDR_AMON: rd_mux = {s_r.afe, s_r.square_wave_enable, s_r.abe, s_r.amon};
            `RSW_ADDR_WDOG: rd_mux = s_r.wd;
            `RSW_ADDR_CTRL: rd_mux = s_r.ctl;
            `RSW_ADDR_SECS: rd_mux = {s_r.st, s_r.secs};
            `RSW_ADDR_WDAY: rd_mux = {1'b0, s_r.ft, 3'h0, s_r.wday};
            default: rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.sec_tick = 1'b0;

        // read snapshot holds until address or enable changes
        s_nxt.rd_act = rd_cond;
        s_nxt.addr_last = addr_q;
        s_nxt.data_oe = rd_cond;
        if (new_rd) begin
            s_nxt.rd_data = rd_mux;
            if (addr_q == `RSW_ADDR_FLAGS) begin
                s_nxt.watchdog_timeout_flag = 1'b0;
            end
        end

        // writes commit when the strobe ends
        s_nxt.wr_act = wr_cond;
        if (wr_cond) begin
            s_nxt.wr_addr = addr_q;
            s_nxt.wr_data = data_q;
        end
        if (commit) begin
            case (s_r.wr_addr)
                `RSW_ADDR_FLAGS: s_nxt.rate = s_r.wr_data[3:0];
                `RSW_ADDR_AMON: begin
                    s_nxt.afe = s_r.wr_data[`RSW_AM_AFE];
                    s_nxt.square_wave_enable = s_r.wr_data[`RSW_AM_SQUARE_WAVE_ENABLE];
                    s_nxt.abe = s_r.wr_data[`RSW_AM_ABE];
                    s_nxt.amon = s_r.wr_data[4:0];
                end
                `RSW_ADDR_WDOG: begin
                    s_nxt.wd = s_r.wr_data;
                    if (s_r.wr_data == 8'h00) begin
                        s_nxt.wd_irq = 1'b0;
                    end
                end
                `RSW_ADDR_CTRL: s_nxt.ctl = s_r.wr_data;
                `RSW_ADDR_SECS: begin
                    s_nxt.st = s_r.wr_data[`RSW_SEC_STOP];
                    s_nxt.secs = s_r.wr_data[6:0];
                end
                `RSW_ADDR_WDAY: begin
                    s_nxt.ft = s_r.wr_data[`RSW_DAY_FT];
                    s_nxt.wday = s_r.wr_data[2:0];
                end
                default: ;
            endcase
        end

        // oscillator divider runs free; ph frozen by the stop bit
        s_nxt.half_cnt = half_tick ? 16'h0000 : s_r.half_cnt + 16'h0001;
        if (half_tick && !s_r.st) begin
            s_nxt.ph = s_r.ph + 16'h0001;
        end

        // watchdog countdown
        s_nxt.kick_last = kick_q;
        if (kick_edge || wd_wr) begin
            s_nxt.wd_pre = 17'h00000;
            s_nxt.wd_cnt = 5'h00;
            s_nxt.wd_done = 1'b0;
        end else if (osc_tick && wd_run) begin
            if (res_wrap) begin
                s_nxt.wd_pre = 17'h00000;
                s_nxt.wd_cnt = s_r.wd_cnt + 5'h01;
            end else begin
                s_nxt.wd_pre = s_r.wd_pre + 17'h00001;
            end
        end
        if (tmo) begin
            s_nxt.watchdog_timeout_flag = 1'b1;
            s_nxt.wd_done = 1'b1;
            if (s_r.wd[`RSW_WD_STEER]) begin
                s_nxt.wd = 8'h00;
                s_nxt.afe = 1'b0;
                s_nxt.square_wave_enable = 1'b0;
                s_nxt.abe = 1'b0;
                s_nxt.ft = 1'b0;
            end else begin
                s_nxt.wd_irq = 1'b1;
            end
        end

        // calibrated seconds chain
        if (osc_tick) begin
            if (s_r.sec_pre == sec_last) begin
                s_nxt.sec_pre = 16'h0000;
                s_nxt.sec_tick = 1'b1;
                if (s_r.sec_cnt == `RSW_LAST_SEC) begin
                    s_nxt.sec_cnt = 6'h00;
                    s_nxt.min_cnt = s_r.min_cnt + 6'h01;
                end else begin
                    s_nxt.sec_cnt = s_r.sec_cnt + 6'h01;
                end
            end else begin
                s_nxt.sec_pre = s_r.sec_pre + 16'h0001;
            end
        end

        // reset output sequencing
        unique case (s_r.rst_st)
            RSW_RST_IDLE: begin
                if (hold_src) begin
                    s_nxt.rst_st = RSW_RST_HOLD;
                end else if (tmo && s_r.wd[`RSW_WD_STEER]) begin
                    s_nxt.rst_st = RSW_RST_RECOVER;
                    s_nxt.rst_cnt = 24'h000000;
                end
            end
            RSW_RST_HOLD: begin
                if (!hold_src) begin
                    s_nxt.rst_st = RSW_RST_RECOVER;
                    s_nxt.rst_cnt = 24'h000000;
                end
            end
            RSW_RST_RECOVER: begin
                if (hold_src) begin
                    s_nxt.rst_st = RSW_RST_HOLD;
                end else if (s_r.rst_cnt == 24'(REC_CYC - 1) && !(tmo && s_r.wd[`RSW_WD_STEER])) begin
                    s_nxt.rst_st = RSW_RST_IDLE;
                end else begin
                    s_nxt.rst_cnt = (tmo && s_r.wd[`RSW_WD_STEER]) ? 24'h000000 : s_r.rst_cnt + 24'h000001;
                end
            end
        endcase

        // external reset clears like a power cycle
        if (ext_rst) begin
            s_nxt.ctl[7:6] = 2'h0;
            s_nxt.ft = 1'b0;
            s_nxt.afe = 1'b0;
            s_nxt.abe = 1'b0;
            s_nxt.square_wave_enable = 1'b0;
            s_nxt.wd = 8'h00;
            s_nxt.wd_irq = 1'b0;
        end
        // power-down clears watchdog and test bit
        if (pf_q) begin
            s_nxt.wd = 8'h00;
            s_nxt.wd_irq = 1'b0;
            s_nxt.ft = 1'b0;
            s_nxt.ctl[7:6] = 2'h0;
        end

        // pins
        s_nxt.irq_oe = s_r.wd_irq || (s_r.afe && i_alarm_flag)
                       || (ft_active && !s_r.ph[`RSW_FT_BIT]);
        s_nxt.sqw_oe = s_r.square_wave_enable && s_r.rate != 4'h0;
        s_nxt.square_wave_pin = s_r.ph[(s_r.rate == 4'h1) ? 4'h0 : s_r.rate];
        s_nxt.rst_oe = s_nxt.rst_st != RSW_RST_IDLE;
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            s_r <= '0;
            s_r.rst_st <= RSW_RST_RECOVER;
            s_r.rst_oe <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_data = s_r.rd_data;
    assign o_data_oe = s_r.data_oe;
    assign o_interrupt_test_pin_out = s_r.irq_out;
    assign o_interrupt_test_pin_oe = s_r.irq_oe;
    assign o_square_wave_pin = s_r.square_wave_pin;
    assign o_square_wave_pin_oe = s_r.sqw_oe;
    assign o_reset_out = s_r.rst_out;
    assign o_reset_oe = s_r.rst_oe;
    assign o_second_tick = s_r.sec_tick;

    // oscillator ticks since the last restart
    logic [22:0] chk_ticks;
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || kick_edge || wd_wr) begin
            chk_ticks <= 23'h000000;
        end else if (osc_tick && wd_run) begin
            chk_ticks <= chk_ticks + 23'h000001;
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    tmo_length_a: assert property (tmo |-> 23'(chk_ticks + 23'h000001) ==
                                   23'(23'(wd_mult) * (23'(res_last) + 23'h000001)))
        else $error("watchdog timeout at wrong tick count");
    wdf_set_a: assert property (tmo |=> s_r.watchdog_timeout_flag)
        else $error("watchdog flag not set on timeout");
    wdf_readclr_a: assert property (new_rd && addr_q == `RSW_ADDR_FLAGS && !tmo |=> !s_r.watchdog_timeout_flag)
        else $error("flags read did not clear watchdog flag");
    irq_steer_a: assert property (tmo && !s_r.wd[`RSW_WD_STEER] |=> s_r.wd_irq ##1 o_interrupt_test_pin_oe)
        else $error("interrupt steering did not drive pin");
    rst_steer_a: assert property (tmo && s_r.wd[`RSW_WD_STEER] |=>
                                  s_r.wd == 8'h00 && !s_r.afe && !s_r.square_wave_enable && !s_r.abe && !s_r.ft && o_reset_oe)
        else $error("reset steering did not clear bits or pulse reset");
    kick_restart_a: assert property (kick_edge |=> s_r.wd_cnt == 5'h00 && s_r.wd_pre == 17'h00000)
        else $error("kick edge did not restart watchdog");
    irq_release_a: assert property (wd_wr && s_r.wr_data == 8'h00 |=> !s_r.wd_irq && s_r.wd == 8'h00)
        else $error("zero write did not release interrupt");
    pf_clear_a: assert property (pf_q |=> s_r.wd == 8'h00 && !s_r.ft && o_reset_oe)
        else $error("power fail did not clear watchdog and test bit");
    ft_denied_a: assert property (s_r.wd != 8'h00 && !s_r.wd[`RSW_WD_STEER] && !s_r.wd_irq
                                  && !(s_r.afe && i_alarm_flag) |=> !o_interrupt_test_pin_oe)
        else $error("frequency test not suppressed");
    snapshot_hold_a: assert property (rd_cond && !new_rd |=> $stable(o_data))
        else $error("read data changed without new access");
    sqw_gate_a: assert property (!s_r.square_wave_enable |=> !o_square_wave_pin_oe)
        else $error("square wave driven while disabled");
    irq_timeout_c: cover property (tmo && !s_r.wd[`RSW_WD_STEER]);
    rst_timeout_c: cover property (tmo && s_r.wd[`RSW_WD_STEER]);
    cal_second_c: cover property (osc_tick && cal_here && s_r.sec_pre == sec_last);
    ft_toggle_c: cover property (ft_active && $rose(s_r.ph[`RSW_FT_BIT]));
endmodule // rsw_supervisor

// ### rtl/rsw_sync.sv
`timescale 1ns/1ps
module rsw_sync
    import rsw_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // asynchronous pins
    input wire logic [W-1:0] i_async,
    // qualified levels
    output logic [W-1:0] o_level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } rsw_sync_state_t;

    rsw_sync_state_t s_r, s_nxt;

    // a bit moves only once stages two and three agree
    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = i_async;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        s_nxt.q = (s_r.s3 & ~(s_r.s2 ^ s_r.s3)) | (s_r.q & (s_r.s2 ^ s_r.s3));
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            s_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_level = s_r.q;
endmodule // rsw_sync

// ### tb/rsw_host.sv
`timescale 1ns/1ps
module rsw_host (
    // clock
    input wire logic i_clock,
    // read data from the device
    input wire logic [7:0] i_data,
    input wire logic i_data_oe,
    // bus pins
    output logic [18:0] o_addr,
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic [7:0] o_data
);
    initial begin
        o_addr = 19'h0;
        o_ce_n = 1'b1;
        o_oe_n = 1'b1;
        o_we_n = 1'b1;
        o_data = 8'h00;
    end
    // pins held 8 clocks so the pin synchronisers see them
    task automatic wr(input logic [18:0] a, input logic [7:0] d);
        @(posedge i_clock);
        o_addr <= a;
        o_data <= d;
        o_ce_n <= 1'b0;
        o_we_n <= 1'b0;
        repeat (8) @(posedge i_clock);
        o_ce_n <= 1'b1;
        o_we_n <= 1'b1;
        o_data <= ~d;
        repeat (8) @(posedge i_clock);
    endtask
    // chip enable toggles between reads so flag changes show
    task automatic rd(input logic [18:0] a, output logic [7:0] d);
        @(posedge i_clock);
        o_addr <= a;
        o_ce_n <= 1'b0;
        o_oe_n <= 1'b0;
        repeat (8) @(posedge i_clock);
        // an undriven bus reads back as the inverse
        d = i_data_oe ? i_data : ~i_data;
        o_ce_n <= 1'b1;
        o_oe_n <= 1'b1;
        repeat (8) @(posedge i_clock);
    endtask
endmodule // rsw_host

// ### tb/rsw_supervisor_tb.sv
`timescale 1ns/1ps
`include "rsw_params.svh"
module rsw_supervisor_tb;
    import rsw_pkg::*;
    logic i_clock, i_sys_rst, ce_n, oe_n, we_n, data_oe, kick, fast_n, deb_n, pfail, alarm;
    logic irq_oe, square_wave_pin, sqw_oe, rst_oe, irq_out, rst_out, sec_tick;
    int sec_ticks = 0;
    logic [18:0] addr;
    logic [7:0] wdata, rdata;
    int err_total, comparisons;
    rsw_host host_u (.i_clock(i_clock), .i_data(rdata), .i_data_oe(data_oe), .o_addr(addr), .o_ce_n(ce_n), .o_oe_n(oe_n),
        .o_we_n(we_n), .o_data(wdata));
    rsw_supervisor #(.HALF_DIV(4), .DEB_CYC(40), .REC_CYC(20)) dut_u (.i_clock(i_clock),
        .i_sys_rst(i_sys_rst), .i_addr(addr), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
        .i_data(wdata), .o_data(rdata), .o_data_oe(data_oe), .i_watchdog_kick_input(kick),
        .i_fast_reset_input_n(fast_n), .i_debounced_reset_input_n(deb_n), .i_power_fail(pfail),
        .i_alarm_flag(alarm), .o_interrupt_test_pin_out(irq_out), .o_interrupt_test_pin_oe(irq_oe),
        .o_square_wave_pin(square_wave_pin), .o_square_wave_pin_oe(sqw_oe), .o_reset_out(rst_out),
        .o_reset_oe(rst_oe), .o_second_tick(sec_tick));
    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    // a full second is far longer than the whole run
    always @(negedge i_clock) begin
        if (sec_tick === 1'b1) begin
            sec_ticks <= sec_ticks + 1;
        end
    end
    task automatic summarize();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rchk(input string nm, input logic [18:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_u.rd(a, d);
        chk(nm, exp, d);
        chk("data_oe_off", 8'h00, {7'h0, data_oe});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    function automatic logic sig(input int s);
        return s == 0 ? irq_oe : (s == 1 ? rst_oe : square_wave_pin);
    endfunction
    task automatic wait_for(input int s, input logic v, input int lim, output int n);
        n = 0;
        while (sig(s) !== v && n < lim) begin
            @(negedge i_clock);
            n++;
        end
        if (sig(s) !== v) begin
            err_total++;
            $display("Error wait on output %0d timed out", s);
            summarize();
        end
    endtask
    task automatic count_edges(input int cyc, output int c);
        logic p;
        c = 0;
        p = square_wave_pin;
        repeat (cyc) begin
            @(negedge i_clock);
            c += (square_wave_pin !== p);
            p = square_wave_pin;
        end
    endtask
    task automatic t_regs();
        host_u.wr(`RSW_ADDR_AMON, 8'h1f);
        host_u.wr(`RSW_ADDR_CTRL, 8'h3a);
        host_u.wr(`RSW_ADDR_FLAGS, 8'h03);
        host_u.wr(19'h00010, 8'haa);
        rchk("amon", `RSW_ADDR_AMON, 8'h1f);
        rchk("ctrl", `RSW_ADDR_CTRL, 8'h3a);
        rchk("flags", `RSW_ADDR_FLAGS, 8'h03);
        rchk("unmapped", 19'h00010, 8'h00);
    endtask
    task automatic t_wd_irq();
        int n;
        host_u.wr(`RSW_ADDR_WDOG, 8'h04);
        wait_for(0, 1'b1, 20000, n);
        chk("wd_period_ok", 8'h01, {7'h0, n > 16300 && n < 16500});
        rchk("flags_wdf", `RSW_ADDR_FLAGS, 8'h83);
        rchk("flags_clear", `RSW_ADDR_FLAGS, 8'h03);
        chk("irq_held", 8'h01, {7'h0, irq_oe});
        host_u.wr(`RSW_ADDR_WDOG, 8'h00);
        chk("irq_released", 8'h00, {7'h0, irq_oe});
    endtask
    task automatic t_kick();
        int n, hits;
        hits = 0;
        host_u.wr(`RSW_ADDR_WDAY, 8'h40);
        host_u.wr(`RSW_ADDR_WDOG, 8'h04);
        repeat (1000) begin
            @(negedge i_clock);
            hits += irq_oe;
        end
        chk("ft_denied", 8'h00, {7'h0, hits != 0});
        idle(9000);
        host_u.wr(`RSW_ADDR_WDOG, 8'h04);
        idle(10000);
        kick <= ~kick;
        idle(10000);
        chk("irq_after_restart", 8'h00, {7'h0, irq_oe});
        wait_for(0, 1'b1, 8000, n);
        host_u.wr(`RSW_ADDR_WDOG, 8'h00);
        wait_for(0, 1'b1, 600, n);
        wait_for(0, 1'b0, 600, n);
    endtask
    task automatic t_steer();
        int n;
        host_u.wr(`RSW_ADDR_AMON, 8'h40);
        host_u.wr(`RSW_ADDR_WDOG, 8'h84);
        wait_for(0, 1'b1, 600, n);
        wait_for(1, 1'b1, 20000, n);
        wait_for(1, 1'b0, 100, n);
        rchk("wd_cleared", `RSW_ADDR_WDOG, 8'h00);
        rchk("amon_cleared", `RSW_ADDR_AMON, 8'h00);
        rchk("ft_cleared", `RSW_ADDR_WDAY, 8'h00);
        rchk("flags_wdf2", `RSW_ADDR_FLAGS, 8'h83);
    endtask
    task automatic t_sqw();
        int c;
        host_u.wr(`RSW_ADDR_AMON, 8'h40);
        for (int r = 1; r < 3; r++) begin
            host_u.wr(`RSW_ADDR_FLAGS, r[7:0]);
            chk("sqw_on", 8'h01, {7'h0, sqw_oe});
            count_edges(64, c);
            chk("sqw_rate_ok", 8'h01, {7'h0, c >= (r == 1 ? 15 : 3) && c <= (r == 1 ? 16 : 4)});
        end
        host_u.wr(`RSW_ADDR_FLAGS, 8'h00);
        chk("sqw_hiz", 8'h00, {7'h0, sqw_oe});
        host_u.wr(`RSW_ADDR_FLAGS, 8'h01);
        host_u.wr(`RSW_ADDR_AMON, 8'h00);
        chk("sqw_off", 8'h00, {7'h0, sqw_oe});
    endtask
    task automatic pulse(input int i, input int len);
        @(posedge i_clock);
        if (i == 0) fast_n <= 1'b0;
        else deb_n <= 1'b0;
        idle(len);
        fast_n <= 1'b1;
        deb_n <= 1'b1;
        @(negedge i_clock);
    endtask
    task automatic t_rst_inputs();
        int n;
        for (int i = 0; i < 2; i++) begin
            pulse(i, i ? 20 : 5);
            idle(60);
            chk("short_ignored", 8'h00, {7'h0, rst_oe});
            host_u.wr(`RSW_ADDR_WDOG, 8'h0c);
            pulse(i, i ? 60 : 30);
            chk("long_taken", 8'h01, {7'h0, rst_oe});
            wait_for(1, 1'b0, 100, n);
            chk("recovery_ok", 8'h01, {7'h0, n >= 20});
            rchk("wd_ext_cleared", `RSW_ADDR_WDOG, 8'h00);
        end
    endtask
    task automatic t_pfail();
        int n;
        host_u.wr(`RSW_ADDR_WDOG, 8'h0c);
        host_u.wr(`RSW_ADDR_WDAY, 8'h40);
        pfail <= 1'b1;
        idle(20);
        chk("pf_reset", 8'h01, {7'h0, rst_oe});
        pfail <= 1'b0;
        wait_for(1, 1'b0, 100, n);
        chk("pf_recovery", 8'h01, {7'h0, n >= 20});
        rchk("wd_pf_cleared", `RSW_ADDR_WDOG, 8'h00);
        rchk("ft_pf_cleared", `RSW_ADDR_WDAY, 8'h00);
    endtask
    initial begin
        int n;
        err_total = 0;
        comparisons = 0;
        i_sys_rst = 1'b1;
        kick = 1'b0;
        fast_n = 1'b1;
        deb_n = 1'b1;
        pfail = 1'b0;
        alarm = 1'b0;
        idle(3);
        i_sys_rst <= 1'b0;
        @(negedge i_clock);
        chk("rst_after_reset", 8'h01, {7'h0, rst_oe});
        wait_for(1, 1'b0, 100, n);
        t_regs();
        t_wd_irq();
        t_kick();
        t_steer();
        t_sqw();
        t_rst_inputs();
        t_pfail();
        chk("od_levels", 8'h00, {6'h0, irq_out, rst_out});
        chk("no_early_second", 8'h00, {7'h0, sec_ticks != 0});
        summarize();
    end
endmodule // rsw_supervisor_tb
